/* design/usb_cmd_map.svh */
// register map, command codes and field positions of the command port
`ifndef USB_CMD_MAP_SVH
`define USB_CMD_MAP_SVH
`define SLAVE_PREFIX 6'h17
`define ADDR_UNUSED 2'h3
`define ADDR_CMD_BIT 1
`define ADDR_READ_BIT 0
`define BIT_ACK 4'h8
`define BIT_LAST 4'h7
`define CMD_GRP_SEL 2'h0
`define CMD_GRP_STATUS 2'h1
`define CMD_GRP_INFO 2'h2
`define CMD_REGBANK_HI 4'hD
`define CMD_NONUSB 8'hE8
`define CMD_DATA 8'hF0
`define CMD_ACK_SETUP 8'hF1
`define CMD_BUF_EMPTY 8'hF2
`define CMD_SET_MODE 8'hF3
`define CMD_READ_IRQ 8'hF4
`define CMD_READ_FRAME 8'hF5
`define CMD_RESUME 8'hF6
`define CMD_STAT_CHG 8'hF7
`define CMD_BUF_FULL 8'hFA
`define NUM_EP 6'h06
`define EP_CTRL_COUNT 6'h02
`define PHYS_IN_OFS 4'h2
`define PHYS_NONE 4'hF
`define TOP_BASE 8'h08
`define SM_SUSP 2'h0
`define SM_CLKOFF 2'h1
`define SM_ENGINE 2'h2
`define SM_DONE 2'h3
`define ENG_AUDIO_IRQ 4
`define ENG_VIDEO_IRQ 3
`define ENG_AUDIO_EN 2
`define ENG_VIDEO_EN 1
`define ENG_ERR_ONLY 0
`define TIMER_RST 8'h00
`endif

/* design/usb_cmd_pkg.sv */
// types shared by the command port and its users
package usb_cmd_pkg;
  typedef enum logic [3:0] {
    OP_SELECT, OP_STATUS, OP_INIT_STATUS, OP_ACK_SETUP, OP_BUF_EMPTY,
    OP_BUF_FULL, OP_RESUME, OP_STATUS_CHANGE, OP_DATA_WRITE, OP_DATA_READ,
    OP_REG_WRITE, OP_REG_READ, OP_TOP_WRITE
  } mm_op_e;
  typedef enum logic [2:0] {
    M_NONE, M_STATUS, M_REGBANK, M_NONUSB, M_DATA, M_SETMODE, M_IRQ, M_FRAME
  } cmd_mode_e;
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_WRITE, L_READ} link_e;
  typedef struct packed {
    logic valid;
    mm_op_e op;
    logic [5:0] ep;
    logic [3:0] phys_out;
    logic [3:0] phys_in;
    logic [7:0] addr;
    logic [7:0] data;
  } mm_req_s;
  typedef struct packed {
    logic [7:0] suspend_powerdown_timer;
    logic [7:0] clock_off_delay_timer;
    logic audio_irq_en;
    logic video_irq_en;
    logic audio_ep_en;
    logic video_ep_en;
    logic error_only;
  } engine_cfg_s;
endpackage

/* design/usb_mmu_i2c_command_port.sv */
// i2c command and data port of the usb memory manager
`timescale 1ns/1ps
`default_nettype none
`include "usb_cmd_map.svh"
module usb_mmu_i2c_command_port #(
  parameter int IRQ_W = 16,
  parameter int FRAME_W = 11
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic usb_bus_reset,
  input wire logic [IRQ_W-1:0] irq_status,
  input wire logic [FRAME_W-1:0] frame_number,
  input wire logic [7:0] mm_rd_data,
  output usb_cmd_pkg::mm_req_s mm_req,
  output usb_cmd_pkg::engine_cfg_s engine_cfg
);
  import usb_cmd_pkg::*;

  // start condition: sda falls while scl high
  logic start_tgl;
  always_ff @(negedge sda_in or posedge rst)
  begin
    if (rst)
    begin
      start_tgl <= 1'b0;
    end
    else if (scl_clk)
    begin
      start_tgl <= ~start_tgl;
    end
  end

  // link side, sampled on rising scl
  link_e st, next_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] sh, next_sh;
  logic is_cmd, next_is_cmd;
  logic start_ack, next_start_ack;
  logic wr_tgl, next_wr_tgl;
  logic [7:0] wr_byte, next_wr_byte;
  logic wr_cmd, next_wr_cmd;
  logic rd_tgl, next_rd_tgl;
  logic start_seen;
  logic addr_ok;
  link_e st_eff;
  logic [3:0] bit_eff;
  logic [7:0] rd_byte;

  assign start_seen = start_tgl != start_ack;
  assign addr_ok = (sh[7:2] == `SLAVE_PREFIX) &&
                   (sh[1:0] != `ADDR_UNUSED);

  always_comb
  begin
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_sh = sh;
    next_is_cmd = is_cmd;
    next_start_ack = start_ack;
    next_wr_tgl = wr_tgl;
    next_wr_byte = wr_byte;
    next_wr_cmd = wr_cmd;
    next_rd_tgl = rd_tgl;
    st_eff = start_seen ? L_ADDR : st;
    bit_eff = start_seen ? 4'h0 : bit_cnt;
    if (start_seen)
    begin
      next_start_ack = start_tgl;
      next_st = L_ADDR;
    end
    case (st_eff)
      L_ADDR:
      begin
        if (bit_eff == `BIT_ACK)
        begin
          next_bit_cnt = 4'h0;
          next_is_cmd = sh[`ADDR_CMD_BIT];
          if (!addr_ok)
          begin
            next_st = L_IDLE;
          end
          else if (sh[`ADDR_READ_BIT])
          begin
            next_st = L_READ;
          end
          else
          begin
            next_st = L_WRITE;
          end
        end
        else
        begin
          next_sh = {sh[6:0], sda_in};
          next_bit_cnt = bit_eff + 4'h1;
        end
      end
      L_WRITE:
      begin
        if (bit_eff == `BIT_ACK)
        begin
          next_bit_cnt = 4'h0;
        end
        else
        begin
          next_sh = {sh[6:0], sda_in};
          next_bit_cnt = bit_eff + 4'h1;
          if (bit_eff == `BIT_LAST)
          begin
            next_wr_byte = {sh[6:0], sda_in};
            next_wr_cmd = is_cmd;
            next_wr_tgl = ~wr_tgl;
          end
        end
      end
      L_READ:
      begin
        if (bit_eff == `BIT_ACK)
        begin
          next_bit_cnt = 4'h0;
          if (sda_in)
          begin
            next_st = L_IDLE;
          end
        end
        else
        begin
          next_bit_cnt = bit_eff + 4'h1;
          if (bit_eff == 4'h0)
          begin
            next_rd_tgl = ~rd_tgl;
          end
        end
      end
      default:
      begin
        next_bit_cnt = bit_cnt;
      end
    endcase
  end

  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= L_IDLE;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      is_cmd <= 1'b0;
      start_ack <= 1'b0;
      wr_tgl <= 1'b0;
      wr_byte <= 8'h00;
      wr_cmd <= 1'b0;
      rd_tgl <= 1'b0;
    end
    else
    begin
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      sh <= next_sh;
      is_cmd <= next_is_cmd;
      start_ack <= next_start_ack;
      wr_tgl <= next_wr_tgl;
      wr_byte <= next_wr_byte;
      wr_cmd <= next_wr_cmd;
      rd_tgl <= next_rd_tgl;
    end
  end

  // link side, sda driven on falling scl
  logic [7:0] tx_sh, next_tx_sh;
  logic drive, next_drive;

  always_comb
  begin
    next_tx_sh = tx_sh;
    next_drive = 1'b0;
    if (!start_seen)
    begin
      case (st)
        L_ADDR:
        begin
          next_drive = (bit_cnt == `BIT_ACK) && addr_ok;
        end
        L_WRITE:
        begin
          next_drive = bit_cnt == `BIT_ACK;
        end
        L_READ:
        begin
          if (bit_cnt == 4'h0)
          begin
            next_tx_sh = rd_byte;
            next_drive = ~rd_byte[7];
          end
          else if (bit_cnt != `BIT_ACK)
          begin
            next_tx_sh = {tx_sh[6:0], 1'b0};
            next_drive = ~tx_sh[6];
          end
        end
        default:
        begin
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_sh <= 8'h00;
      drive <= 1'b0;
    end
    else
    begin
      tx_sh <= next_tx_sh;
      drive <= next_drive;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive;

  // event crossing into the system clock
  logic [2:0] wr_sync, next_wr_sync;
  logic [2:0] rd_sync, next_rd_sync;
  logic wr_ev, rd_ev;

  assign next_wr_sync = {wr_sync[1:0], wr_tgl};
  assign next_rd_sync = {rd_sync[1:0], rd_tgl};
  assign wr_ev = wr_sync[1] ^ wr_sync[2];
  assign rd_ev = rd_sync[1] ^ rd_sync[2];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
    end
    else
    begin
      wr_sync <= next_wr_sync;
      rd_sync <= next_rd_sync;
    end
  end

  // command interpreter
  cmd_mode_e mode, next_mode;
  logic [5:0] sel_ep, next_sel_ep;
  logic [3:0] reg_addr, next_reg_addr;
  logic [1:0] sm_idx, next_sm_idx;
  logic [7:0] top_ptr, next_top_ptr;
  logic byte_idx, next_byte_idx;
  logic [7:0] next_rd_byte;
  mm_req_s next_mm_req;
  engine_cfg_s next_engine_cfg;
  logic [15:0] irq_wide, frame_wide;

  assign irq_wide = 16'(irq_status);
  assign frame_wide = 16'(frame_number);

  function automatic mm_req_s mk_req(input mm_op_e op,
                                     input logic [5:0] ep,
                                     input logic [7:0] addr,
                                     input logic [7:0] data);
    mm_req_s r;
    r.valid = 1'b1;
    r.op = op;
    r.ep = ep;
    r.addr = addr;
    r.data = data;
    if (ep < `EP_CTRL_COUNT)
    begin
      r.phys_out = {ep[2:0], 1'b0};
      r.phys_in = {ep[2:0], 1'b1};
    end
    else
    begin
      r.phys_out = `PHYS_NONE;
      r.phys_in = ep[3:0] + `PHYS_IN_OFS;
    end
    return r;
  endfunction

  always_comb
  begin
    next_mode = mode;
    next_sel_ep = sel_ep;
    next_reg_addr = reg_addr;
    next_sm_idx = sm_idx;
    next_top_ptr = top_ptr;
    next_byte_idx = byte_idx;
    next_mm_req = '0;
    next_engine_cfg = engine_cfg;
    if (usb_bus_reset)
    begin
      next_engine_cfg.audio_irq_en = 1'b1;
      next_engine_cfg.video_irq_en = 1'b1;
      next_engine_cfg.audio_ep_en = 1'b1;
      next_engine_cfg.video_ep_en = 1'b1;
    end
    if (wr_ev && wr_cmd)
    begin
      case (wr_byte[7:6])
        `CMD_GRP_SEL, `CMD_GRP_STATUS, `CMD_GRP_INFO:
        begin
          if (wr_byte[5:0] < `NUM_EP)
          begin
            next_sel_ep = wr_byte[5:0];
            if (wr_byte[7:6] == `CMD_GRP_SEL)
            begin
              next_mm_req = mk_req(OP_SELECT, wr_byte[5:0], 8'h00, 8'h00);
            end
            else if (wr_byte[7:6] == `CMD_GRP_STATUS)
            begin
              next_mode = M_STATUS;
              next_mm_req = mk_req(OP_STATUS, wr_byte[5:0], 8'h00, 8'h00);
            end
            else
            begin
              next_mode = M_STATUS;
              next_mm_req = mk_req(OP_INIT_STATUS, wr_byte[5:0], 8'h00,
                                   8'h00);
            end
          end
        end
        default:
        begin
          if (wr_byte[7:4] == `CMD_REGBANK_HI)
          begin
            next_mode = M_REGBANK;
            next_reg_addr = wr_byte[3:0];
          end
          else
          begin
            case (wr_byte)
              `CMD_NONUSB:
              begin
                next_mode = M_NONUSB;
                next_top_ptr = 8'h00;
              end
              `CMD_DATA:
              begin
                next_mode = M_DATA;
              end
              `CMD_ACK_SETUP:
              begin
                next_mm_req = mk_req(OP_ACK_SETUP, sel_ep, 8'h00, 8'h00);
              end
              `CMD_BUF_EMPTY:
              begin
                next_mm_req = mk_req(OP_BUF_EMPTY, sel_ep, 8'h00, 8'h00);
              end
              `CMD_BUF_FULL:
              begin
                next_mm_req = mk_req(OP_BUF_FULL, sel_ep, 8'h00, 8'h00);
              end
              `CMD_READ_IRQ:
              begin
                next_mode = M_IRQ;
                next_byte_idx = 1'b0;
              end
              `CMD_READ_FRAME:
              begin
                next_mode = M_FRAME;
                next_byte_idx = 1'b0;
              end
              `CMD_RESUME:
              begin
                next_mm_req = mk_req(OP_RESUME, sel_ep, 8'h00, 8'h00);
              end
              `CMD_STAT_CHG:
              begin
                next_mm_req = mk_req(OP_STATUS_CHANGE, sel_ep, 8'h00,
                                     8'h00);
              end
              `CMD_SET_MODE:
              begin
                next_mode = M_SETMODE;
                next_sm_idx = `SM_SUSP;
              end
              default:
              begin
                next_mode = mode;
              end
            endcase
          end
        end
      endcase
    end
    else if (wr_ev)
    begin
      case (mode)
        M_SETMODE:
        begin
          case (sm_idx)
            `SM_SUSP:
            begin
              next_engine_cfg.suspend_powerdown_timer = wr_byte;
            end
            `SM_CLKOFF:
            begin
              next_engine_cfg.clock_off_delay_timer = wr_byte;
            end
            `SM_ENGINE:
            begin
              next_engine_cfg.audio_irq_en = wr_byte[`ENG_AUDIO_IRQ];
              next_engine_cfg.video_irq_en = wr_byte[`ENG_VIDEO_IRQ];
              next_engine_cfg.audio_ep_en = wr_byte[`ENG_AUDIO_EN];
              next_engine_cfg.video_ep_en = wr_byte[`ENG_VIDEO_EN];
              next_engine_cfg.error_only = wr_byte[`ENG_ERR_ONLY];
            end
            default:
            begin
              next_sm_idx = sm_idx;
            end
          endcase
          if (sm_idx != `SM_DONE)
          begin
            next_sm_idx = sm_idx + 2'h1;
          end
        end
        M_REGBANK:
        begin
          next_mm_req = mk_req(OP_REG_WRITE, sel_ep, {4'h0, reg_addr},
                               wr_byte);
        end
        M_NONUSB:
        begin
          next_mm_req = mk_req(OP_TOP_WRITE, sel_ep, `TOP_BASE + top_ptr,
                               wr_byte);
          next_top_ptr = top_ptr + 8'h01;
        end
        M_DATA, M_STATUS:
        begin
          next_mm_req = mk_req(OP_DATA_WRITE, sel_ep, 8'h00, wr_byte);
        end
        default:
        begin
          next_mode = mode;
        end
      endcase
    end
    if (rd_ev)
    begin
      case (mode)
        M_IRQ, M_FRAME:
        begin
          next_byte_idx = ~byte_idx;
        end
        M_REGBANK:
        begin
          next_mm_req = mk_req(OP_REG_READ, sel_ep, {4'h0, reg_addr},
                               8'h00);
        end
        default:
        begin
          next_mm_req = mk_req(OP_DATA_READ, sel_ep, 8'h00, 8'h00);
        end
      endcase
    end
    case (mode)
      M_IRQ:
      begin
        next_rd_byte = byte_idx ? irq_wide[15:8] : irq_wide[7:0];
      end
      M_FRAME:
      begin
        next_rd_byte = byte_idx ? frame_wide[15:8] : frame_wide[7:0];
      end
      default:
      begin
        next_rd_byte = mm_rd_data;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode <= M_NONE;
      sel_ep <= 6'h00;
      reg_addr <= 4'h0;
      sm_idx <= `SM_DONE;
      top_ptr <= 8'h00;
      byte_idx <= 1'b0;
      rd_byte <= 8'h00;
      mm_req <= '0;
      engine_cfg.suspend_powerdown_timer <= `TIMER_RST;
      engine_cfg.clock_off_delay_timer <= `TIMER_RST;
      engine_cfg.audio_irq_en <= 1'b1;
      engine_cfg.video_irq_en <= 1'b1;
      engine_cfg.audio_ep_en <= 1'b1;
      engine_cfg.video_ep_en <= 1'b1;
      engine_cfg.error_only <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      sel_ep <= next_sel_ep;
      reg_addr <= next_reg_addr;
      sm_idx <= next_sm_idx;
      top_ptr <= next_top_ptr;
      byte_idx <= next_byte_idx;
      rd_byte <= next_rd_byte;
      mm_req <= next_mm_req;
      engine_cfg <= next_engine_cfg;
    end
  end
endmodule // usb_mmu_i2c_command_port
`default_nettype wire

/* sim/usb_cmd_port_asserts.sv */
// concurrent checks on the command port outputs
`timescale 1ns/1ps
`default_nettype none
module usb_cmd_port_asserts #(
  parameter int IRQ_W = 16,
  parameter int FRAME_W = 11
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sda_out,
  input wire logic usb_bus_reset,
  input wire usb_cmd_pkg::mm_req_s mm_req,
  input wire usb_cmd_pkg::engine_cfg_s engine_cfg
);
  import usb_cmd_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda_out driven high");
  property p_one_pulse;
    mm_req.valid |=> !mm_req.valid;
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("request valid longer than one cycle");
  property p_idle_zero;
    !mm_req.valid |-> mm_req == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("request fields set while not valid");
  property p_phys_map;
    mm_req.valid && mm_req.op == OP_SELECT |-> (mm_req.ep < 6'h02) ?
      (mm_req.phys_out == {mm_req.ep[2:0], 1'b0} &&
       mm_req.phys_in == {mm_req.ep[2:0], 1'b1}) :
      (mm_req.phys_out == 4'hF && mm_req.phys_in == mm_req.ep[3:0] + 4'h2);
  endproperty
  a_phys_map: assert property (p_phys_map)
    else $error("wrong physical buffer mapping");
  property p_ep_range;
    mm_req.valid && mm_req.op inside {OP_SELECT, OP_STATUS, OP_INIT_STATUS}
      |-> mm_req.ep < 6'h06;
  endproperty
  a_ep_range: assert property (p_ep_range)
    else $error("end-point number out of range");
  property p_top_base;
    mm_req.valid && mm_req.op == OP_TOP_WRITE |-> mm_req.addr >= 8'h08;
  endproperty
  a_top_base: assert property (p_top_base)
    else $error("top register write below base");
  property p_bank_addr;
    mm_req.valid && mm_req.op inside {OP_REG_WRITE, OP_REG_READ}
      |-> mm_req.addr[7:4] == 4'h0;
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("register bank address too wide");
  property p_bus_force;
    usb_bus_reset |=> engine_cfg.audio_irq_en && engine_cfg.video_irq_en
      && engine_cfg.audio_ep_en && engine_cfg.video_ep_en;
  endproperty
  a_bus_force: assert property (p_bus_force)
    else $error("bus reset did not force engine bits");
  property p_bus_keep;
    usb_bus_reset |=> $stable(engine_cfg.error_only)
      && $stable(engine_cfg.suspend_powerdown_timer)
      && $stable(engine_cfg.clock_off_delay_timer);
  endproperty
  a_bus_keep: assert property (p_bus_keep)
    else $error("bus reset changed error mode or timers");
  c_top: cover property (mm_req.valid && mm_req.op == OP_TOP_WRITE);
endmodule // usb_cmd_port_asserts
bind usb_mmu_i2c_command_port usb_cmd_port_asserts #(
  .IRQ_W(IRQ_W),
  .FRAME_W(FRAME_W)
) usb_cmd_port_asserts_inst (
  .clk_sys(clk_sys),
  .rst(rst),
  .sda_out(sda_out),
  .usb_bus_reset(usb_bus_reset),
  .mm_req(mm_req),
  .engine_cfg(engine_cfg)
);
`default_nettype wire

/* sim/i2c_mcu_model.sv */
// microcontroller acting as i2c master towards the command port
`timescale 1ns/1ps
`default_nettype none
module i2c_mcu_model #(
  parameter int HALF = 15
) (
  output logic scl_clk,
  output logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b0;
    #HALF scl_clk = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl_clk = 1'b0;
  endtask
  // one scl pulse; data set while scl low, sampled while high
  task automatic clk_bit(input logic b, output logic s);
    sda_low = ~b;
    #HALF scl_clk = 1'b1;
    s = sda;
    #HALF scl_clk = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, ack_n);
  endtask
  // nack on the last byte ends the read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(last, s);
  endtask
  // scl stays high after stop, clock stands still
  task automatic stop();
    sda_low = 1'b1;
    #HALF scl_clk = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
endmodule // i2c_mcu_model
`default_nettype wire

/* sim/usb_mmu_i2c_command_port_bench.sv */
// self-checking bench of the i2c command port
`timescale 1ns/1ps
`default_nettype none
module usb_mmu_i2c_command_port_bench;
  import usb_cmd_pkg::*;
  logic clk_sys, rst, usb_bus_reset, scl_clk, sda_low, sda_out, sda_oe, a;
  logic [15:0] irq_status, v;
  logic [10:0] frame_number;
  logic [7:0] mm_rd_data;
  mm_req_s mm_req, r;
  mm_req_s q[$];
  engine_cfg_s engine_cfg;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire logic sda = ~((sda_oe & ~sda_out) | sda_low);
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  usb_mmu_i2c_command_port #(
    .IRQ_W(16),
    .FRAME_W(11)
  ) usb_mmu_i2c_command_port_inst (
    .clk_sys(clk_sys), .rst(rst), .scl_clk(scl_clk), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .usb_bus_reset(usb_bus_reset),
    .irq_status(irq_status), .frame_number(frame_number),
    .mm_rd_data(mm_rd_data), .mm_req(mm_req), .engine_cfg(engine_cfg)
  );
  i2c_mcu_model i2c_mcu_model_inst (
    .scl_clk(scl_clk), .sda_low(sda_low), .sda(sda)
  );
  always @(posedge clk_sys)
  begin
    cyc++;
    if (mm_req.valid === 1'b1)
      q.push_back(mm_req);
    if (cyc == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task pop(input mm_op_e op);
    if (q.size() == 0)
      r = '0;
    else
      r = q.pop_front();
    chk(r.valid, 1'b1);
    chk(r.op, op);
  endtask
  task cmd(input logic [7:0] c);
    q.delete();
    i2c_mcu_model_inst.start();
    i2c_mcu_model_inst.wbyte(8'h5E, a);
    chk(a, 1'b0);
    i2c_mcu_model_inst.wbyte(c, a);
    chk(a, 1'b0);
    i2c_mcu_model_inst.stop();
    wt(10);
  endtask
  task wd(input logic [31:0] d, input int n);
    i2c_mcu_model_inst.start();
    i2c_mcu_model_inst.wbyte(8'h5C, a);
    chk(a, 1'b0);
    for (int i = n - 1; i >= 0; i--)
      i2c_mcu_model_inst.wbyte(d[8*i +: 8], a);
    i2c_mcu_model_inst.stop();
    wt(10);
  endtask
  task rd(input int n);
    logic [7:0] b;
    v = '0;
    i2c_mcu_model_inst.start();
    i2c_mcu_model_inst.wbyte(8'h5D, a);
    chk(a, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      i2c_mcu_model_inst.rbyte(i == n - 1, b);
      v[8*i +: 8] = b;
    end
    i2c_mcu_model_inst.stop();
    wt(10);
  endtask
  task t_addr();
    logic [7:0] adr [5] = '{8'h5C, 8'h5E, 8'h5F, 8'h1E, 8'h7C};
    logic ack [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    q.delete();
    for (int i = 0; i < 5; i++)
    begin
      i2c_mcu_model_inst.start();
      i2c_mcu_model_inst.wbyte(adr[i], a);
      chk(a, ack[i]);
      i2c_mcu_model_inst.stop();
      wt(10);
    end
    chk(q.size(), 0);
    $display("t_addr done");
  endtask
  task t_cmds();
    logic [7:0] code [8] = '{8'h00, 8'h45, 8'h82, 8'hF1, 8'hF2, 8'hFA,
      8'hF6, 8'hF7};
    mm_op_e op [8] = '{OP_SELECT, OP_STATUS, OP_INIT_STATUS, OP_ACK_SETUP,
      OP_BUF_EMPTY, OP_BUF_FULL, OP_RESUME, OP_STATUS_CHANGE};
    for (int i = 0; i < 8; i++)
    begin
      cmd(code[i]);
      pop(op[i]);
    end
    cmd(8'h01);
    pop(OP_SELECT);
    chk({r.ep, r.phys_out, r.phys_in}, {6'h01, 4'h2, 4'h3});
    cmd(8'h05);
    pop(OP_SELECT);
    chk({r.ep, r.phys_out, r.phys_in}, {6'h05, 4'hF, 4'h7});
    cmd(8'h06);
    chk(q.size(), 0);
    for (int i = 0; i < 8; i++)
    begin
      cmd(8'hE0 + i[7:0]);
      chk(q.size(), 0);
    end
    cmd(8'hF2);
    pop(OP_BUF_EMPTY);
    chk(r.ep, 6'h05);
    $display("t_cmds done");
  endtask
  task t_paths();
    cmd(8'h43);
    q.delete();
    wd(32'h5A, 1);
    pop(OP_DATA_WRITE);
    chk({r.ep, r.data}, {6'h03, 8'h5A});
    cmd(8'hD3);
    q.delete();
    wd(32'hA5, 1);
    pop(OP_REG_WRITE);
    chk({r.addr, r.data}, 16'h03A5);
    mm_rd_data = 8'h69;
    rd(1);
    chk(v, 16'h0069);
    pop(OP_REG_READ);
    chk(r.addr, 8'h03);
    cmd(8'hE8);
    q.delete();
    wd(32'h1122, 2);
    pop(OP_TOP_WRITE);
    chk({r.addr, r.data}, 16'h0811);
    pop(OP_TOP_WRITE);
    chk({r.addr, r.data}, 16'h0922);
    cmd(8'hF0);
    q.delete();
    wd(32'h3C, 1);
    pop(OP_DATA_WRITE);
    chk(r.data, 8'h3C);
    mm_rd_data = 8'h96;
    rd(1);
    chk(v, 16'h0096);
    pop(OP_DATA_READ);
    irq_status = 16'hBEEF;
    cmd(8'hF4);
    rd(2);
    chk(v, 16'hBEEF);
    frame_number = 11'h5A3;
    cmd(8'hF5);
    rd(2);
    chk(v, 16'h05A3);
    $display("t_paths done");
  endtask
  task bus_reset();
    usb_bus_reset = 1'b1;
    wt(2);
    usb_bus_reset = 1'b0;
    wt(2);
  endtask
  task t_mode();
    cmd(8'hF3);
    wd(32'h1234E0, 3);
    chk(engine_cfg, {8'h12, 8'h34, 5'h00});
    bus_reset();
    chk(engine_cfg, {8'h12, 8'h34, 5'h1E});
    cmd(8'hF3);
    wd(32'h567801FF, 4);
    chk(engine_cfg, {8'h56, 8'h78, 5'h01});
    bus_reset();
    chk(engine_cfg, {8'h56, 8'h78, 5'h1F});
    rst = 1'b1;
    wt(16);
    rst = 1'b0;
    wt(4);
    chk(engine_cfg, {16'h0000, 5'h1E});
    $display("t_mode done");
  endtask
  initial
  begin
    rst = 1'b0;
    usb_bus_reset = 1'b0;
    irq_status = 16'h0000;
    frame_number = 11'h000;
    mm_rd_data = 8'h00;
    // a real rising edge so the link-side flops see their reset
    #1;
    rst = 1'b1;
    wt(16);
    rst = 1'b0;
    wt(4);
    chk(engine_cfg, {16'h0000, 5'h1E});
    chk(sda_oe, 1'b0);
    t_addr();
    t_cmds();
    t_paths();
    t_mode();
    test_done();
  end
endmodule // usb_mmu_i2c_command_port_bench
`default_nettype wire
